// File: logic/blit_pkg.sv
package blit_pkg;

	// Register offsets in the engine's memory space.
	localparam int          ADDR_W         = 23;
	localparam logic [22:0] CTRL_OFFSET    = 23'h40_0010;
	localparam logic [22:0] PATBASE_OFFSET = 23'h40_0014;

	// Field positions in the control register.
	localparam int ROP_LSB     = 0;
	localparam int ROP_W       = 8;
	localparam int CORNER_LSB  = 8;
	localparam int SRCSEL_BIT  = 10;
	localparam int SRCDEP_BIT  = 12;
	localparam int SRCMASK_BIT = 13;
	localparam int CMP_LSB     = 14;
	localparam int PATMASK_BIT = 17;
	localparam int PATDEP_BIT  = 18;
	localparam int BUSY_BIT    = 31;

	// Bits of the three-bit colour compare code.
	localparam int CMP_EN_BIT   = 0;
	localparam int CMP_DEST_BIT = 1;
	localparam int CMP_EQ_BIT   = 2;

	// Storable bits; bit 11, bits 30-26 and the status bit are not stored.
	localparam logic [31:0] CTRL_STORE_MASK = 32'h03ff_f7ff;
	localparam logic [31:0] PAT_ADDR_MASK   = 32'h007f_fff8;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam logic [31:0] PAT_RESET       = 32'h0000_0000;

	// Pattern geometry per pixel depth.
	localparam logic [2:0] PAT_LAST_ROW   = 3'h7;
	localparam logic [4:0] ROW_BYTES_MONO = 5'h01;
	localparam logic [4:0] ROW_BYTES_8    = 5'h08;
	localparam logic [4:0] ROW_BYTES_16   = 5'h10;
	localparam logic [4:0] ROW_BYTES_24   = 5'h18;
	localparam logic [5:0] STRIDE_24      = 6'h20;

	// Colour bits compared at each engine depth.
	localparam logic [23:0] DEPTH_MASK_8  = 24'h00_00ff;
	localparam logic [23:0] DEPTH_MASK_16 = 24'h00_ffff;
	localparam logic [23:0] DEPTH_MASK_24 = 24'hff_ffff;

	typedef enum logic [1:0] {DEPTH8, DEPTH16, DEPTH24, DEPTH_RSVD} depth_t;
	typedef enum logic [1:0] {UPPER_LEFT, UPPER_RIGHT, LOWER_LEFT, LOWER_RIGHT} corner_t;

endpackage

// File: logic/rop_if.sv
interface rop_if;
	logic [23:0] pattern;
	logic [23:0] source;
	logic [23:0] dest;
	logic [7:0]  code;
	logic [23:0] result;

	modport user (output pattern, output source, output dest, output code, input result);
	modport unit (input pattern, input source, input dest, input code, output result);
endinterface

// File: logic/rop_unit.sv
module rop_unit (
	rop_if.unit px
);
	// Each result bit indexes the code with its pattern, source and destination bits, P as the top index bit.
	for (genvar i = 0; i < 24; i++) begin : g_bit
		assign px.result[i] = px.code[{px.pattern[i], px.source[i], px.dest[i]}]; // R16
	end
endmodule

// File: logic/pattern_fetch.sv
module pattern_fetch (
	input  wire logic                clock,
	input  wire logic                reset,
	input  wire logic                start,
	input  wire logic [22:0]         base,
	input  wire logic                mono,
	input  wire blit_pkg::depth_t    depth,
	input  wire logic                ready,
	output logic                     valid,
	output logic [22:0]              addr,
	output logic                     busy
);
	typedef enum logic {IDLE, RUN} fstate_t;

	fstate_t     state_q, state_d;
	logic [2:0]  row_q, row_d;
	logic [4:0]  byte_q, byte_d;
	logic [22:0] rowBase_q, rowBase_d;
	logic [22:0] addr_q, addr_d;
	logic [4:0]  rowBytes;
	logic [22:0] stride;

	// A 24-bit row spans 32 bytes but only its first 24 are read.
	always_comb begin
		rowBytes = blit_pkg::ROW_BYTES_8;
		stride   = 23'(blit_pkg::ROW_BYTES_8);
		if (mono) begin // R18
			rowBytes = blit_pkg::ROW_BYTES_MONO;
			stride   = 23'(blit_pkg::ROW_BYTES_MONO);
		end else if (depth == blit_pkg::DEPTH16) begin
			rowBytes = blit_pkg::ROW_BYTES_16;
			stride   = 23'(blit_pkg::ROW_BYTES_16);
		end else if (depth == blit_pkg::DEPTH24) begin
			rowBytes = blit_pkg::ROW_BYTES_24; // R22
			stride   = 23'(blit_pkg::STRIDE_24); // R22
		end
	end

	// Walks eight rows of the 8x8 pattern, one byte address per accepted beat.
	always_comb begin
		state_d   = state_q;
		row_d     = row_q;
		byte_d    = byte_q;
		rowBase_d = rowBase_q;
		addr_d    = addr_q;
		case (state_q)
			IDLE: begin
				if (start) begin
					state_d   = RUN;
					row_d     = 3'h0;
					byte_d    = 5'h00;
					rowBase_d = base;
					addr_d    = base;
				end
			end
			RUN: begin
				if (ready) begin
					if (byte_q == rowBytes - 5'h01) begin
						if (row_q == blit_pkg::PAT_LAST_ROW) begin // R18
							state_d = IDLE;
						end else begin
							row_d     = row_q + 3'h1;
							byte_d    = 5'h00;
							rowBase_d = rowBase_q + stride;
							addr_d    = rowBase_q + stride;
						end
					end else begin
						byte_d = byte_q + 5'h01;
						addr_d = addr_q + 23'h1;
					end
				end
			end
			default: state_d = IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_q   <= IDLE;
			row_q     <= 3'h0;
			byte_q    <= 5'h00;
			rowBase_q <= 23'h0;
			addr_q    <= 23'h0;
		end else begin
			state_q   <= state_d;
			row_q     <= row_d;
			byte_q    <= byte_d;
			rowBase_q <= rowBase_d;
			addr_q    <= addr_d;
		end
	end

	assign valid = (state_q == RUN);
	assign busy  = (state_q == RUN);
	assign addr  = addr_q;
endmodule

// File: logic/blit_mask_source_pattern_ctrl.sv
// Operation
// [R1] Monochrome pattern masking enabled: pixels with pattern bit 0 are not written.
// [R2] Pattern masking acts only while the pattern is marked monochrome.
// [R3] Compare code with low bit 0 disables colour-compare masking.
// [R4] Code 001: write when background differs from raster-op result.
// [R5] Code 011: write when background differs from existing destination colour.
// [R6] Code 101: write when background equals raster-op result.
// [R7] Code 111: write when background equals existing destination colour.
// [R8] Monochrome source masking enabled: pixels with source bit 0 are not written.
// [R9] Source depth bit: 0 colour at engine depth, 1 monochrome.
// [R10] Software picks monochrome source only with low corner bit clear.
// [R11] Control bit 11 always reads zero.
// [R12] Source select 0 fetches source from frame buffer at source address.
// [R13] Source select 1 takes source from host writes to the data port.
// [R14] Corner field chooses start corner; upper left after reset.
// [R15] Software points operand addresses at the starting-corner pixel.
// [R16] Eight-bit code selects one of 256 bitwise raster operations.
// [R17] Pattern base holds offset bits 22-3; other bits read zero.
// [R18] Every pattern is an 8x8 pixel array sized by pixel depth.
// [R19] Software aligns monochrome patterns to quadword boundaries.
// [R20] Software aligns colour patterns to 64, 128 or 256 bytes.
// [R21] Software keeps colour pattern depth equal to engine depth.
// [R22] 24-bit rows span 32 bytes; only first 24 are read.
// [R23] Pattern depth bit 1 marks monochrome pattern, 0 colour.
// [R24] Status bit reads engine busy; writes to it are ignored.
// [R25] With several masks enabled, write only if all allow it.
module blit_mask_source_pattern_ctrl (
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic [22:0]      regAddr,
	input  wire logic             regWrite,
	input  wire logic             regRead,
	input  wire logic [3:0]       regByteEn,
	input  wire logic [31:0]      regWriteData,
	output logic [31:0]           regReadData,
	output logic                  regReadValid,
	input  wire logic             engineBusy,
	input  wire blit_pkg::depth_t engineDepth,
	input  wire logic [23:0]      srcExpBackground,
	input  wire logic             dataPortWrite,
	input  wire logic [31:0]      dataPortData,
	output logic                  dataPortReady,
	input  wire logic             fbSrcValid,
	input  wire logic [31:0]      fbSrcData,
	output logic                  fbSrcReady,
	output logic                  srcOutValid,
	output logic [31:0]           srcOutData,
	input  wire logic             srcOutReady,
	input  wire logic             pixInValid,
	output logic                  pixInReady,
	input  wire logic             patBit,
	input  wire logic             srcBit,
	input  wire logic [23:0]      patColour,
	input  wire logic [23:0]      srcColour,
	input  wire logic [23:0]      dstColour,
	output logic                  pixOutValid,
	output logic [23:0]           pixOutColour,
	output logic                  pixOutWrite,
	input  wire logic             pixOutReady,
	output logic                  sourceFromHost,
	output logic                  sourceMono,
	output logic                  patternMono,
	output blit_pkg::corner_t     startCorner,
	output logic                  startRight,
	output logic                  startBottom,
	input  wire logic             patFetchStart,
	input  wire logic             patFetchReady,
	output logic                  patFetchValid,
	output logic [22:0]           patFetchAddr
);
	logic [31:0] ctrl_q, ctrl_d;
	logic [31:0] patBase_q, patBase_d;
	logic [31:0] rdata_q, rdata_d;
	logic        rvalid_q, rvalid_d;
	logic [31:0] laneMask;
	logic        fetchBusy;
	logic        ctrlHit;
	logic        patHit;

	logic [7:0]  ropCode;
	logic [2:0]  cmpCode;
	logic        patMaskEn;
	logic        srcMaskEn;

	// Field views of the control register.
	assign ropCode        = ctrl_q[blit_pkg::ROP_LSB +: blit_pkg::ROP_W]; // R16
	assign startCorner    = blit_pkg::corner_t'(ctrl_q[blit_pkg::CORNER_LSB +: 2]); // R14
	assign sourceFromHost = ctrl_q[blit_pkg::SRCSEL_BIT];
	assign sourceMono     = ctrl_q[blit_pkg::SRCDEP_BIT]; // R9
	assign srcMaskEn      = ctrl_q[blit_pkg::SRCMASK_BIT];
	assign cmpCode        = ctrl_q[blit_pkg::CMP_LSB +: 3];
	assign patMaskEn      = ctrl_q[blit_pkg::PATMASK_BIT];
	assign patternMono    = ctrl_q[blit_pkg::PATDEP_BIT]; // R23

	// Right and bottom starts make the engine walk columns and rows backwards.
	assign startRight  = (startCorner == blit_pkg::UPPER_RIGHT) || (startCorner == blit_pkg::LOWER_RIGHT); // R14
	assign startBottom = (startCorner == blit_pkg::LOWER_LEFT) || (startCorner == blit_pkg::LOWER_RIGHT); // R14

	// Byte enables widen into a bit mask so word writes touch only their half.
	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign laneMask[8*b +: 8] = {8{regByteEn[b]}};
	end

	assign ctrlHit = (regAddr == blit_pkg::CTRL_OFFSET);
	assign patHit  = (regAddr == blit_pkg::PATBASE_OFFSET);

	// Register writes and registered read answers.
	always_comb begin
		ctrl_d    = ctrl_q;
		patBase_d = patBase_q;
		rdata_d   = rdata_q;
		rvalid_d  = regRead;
		if (regWrite && ctrlHit) begin
			// The status bit and bit 11 are not stored, so writes to them vanish.
			ctrl_d = (ctrl_q & ~(laneMask & blit_pkg::CTRL_STORE_MASK))
				| (regWriteData & laneMask & blit_pkg::CTRL_STORE_MASK); // R24 R11
		end else if (regWrite && patHit) begin
			patBase_d = (patBase_q & ~(laneMask & blit_pkg::PAT_ADDR_MASK))
				| (regWriteData & laneMask & blit_pkg::PAT_ADDR_MASK); // R17
		end
		if (regRead) begin
			if (ctrlHit) begin
				rdata_d = ctrl_q & blit_pkg::CTRL_STORE_MASK; // R11
				rdata_d[blit_pkg::BUSY_BIT] = engineBusy || fetchBusy; // R24
			end else if (patHit) begin
				rdata_d = patBase_q & blit_pkg::PAT_ADDR_MASK; // R17
			end else begin
				rdata_d = 32'h0000_0000;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ctrl_q    <= blit_pkg::CTRL_RESET; // R14
			patBase_q <= blit_pkg::PAT_RESET;
			rdata_q   <= 32'h0000_0000;
			rvalid_q  <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			patBase_q <= patBase_d;
			rdata_q   <= rdata_d;
			rvalid_q  <= rvalid_d;
		end
	end

	assign regReadData  = rdata_q;
	assign regReadValid = rvalid_q;

	// Pattern byte fetch; geometry follows the pattern and engine depths.
	pattern_fetch u_fetch (
		.clock (clock),
		.reset (reset),
		.start (patFetchStart),
		.base  (patBase_q[22:0]),
		.mono  (patternMono),
		.depth (engineDepth),
		.ready (patFetchReady),
		.valid (patFetchValid),
		.addr  (patFetchAddr),
		.busy  (fetchBusy)
	);

	// Source stream: one register stage fed either by memory or by the host.
	logic [31:0] srcData_q, srcData_d;
	logic        srcValid_q, srcValid_d;
	logic        srcTake;
	logic        srcInValid;
	logic [31:0] srcInData;

	assign srcTake       = !srcValid_q || srcOutReady;
	assign dataPortReady = sourceFromHost && srcTake; // R13
	assign fbSrcReady    = !sourceFromHost && srcTake; // R12

	// A host write while memory is selected is refused by a low ready and dropped.
	always_comb begin
		if (sourceFromHost) begin
			srcInValid = dataPortWrite; // R13
			srcInData  = dataPortData;
		end else begin
			srcInValid = fbSrcValid; // R12
			srcInData  = fbSrcData;
		end
	end

	always_comb begin
		srcData_d  = srcData_q;
		srcValid_d = srcValid_q;
		if (srcTake) begin
			srcValid_d = srcInValid;
			if (srcInValid) begin
				srcData_d = srcInData;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			srcData_q  <= 32'h0000_0000;
			srcValid_q <= 1'b0;
		end else begin
			srcData_q  <= srcData_d;
			srcValid_q <= srcValid_d;
		end
	end

	assign srcOutValid = srcValid_q;
	assign srcOutData  = srcData_q;

	// Raster operation on the three operands.
	rop_if ropBus ();

	assign ropBus.pattern = patColour;
	assign ropBus.source  = srcColour;
	assign ropBus.dest    = dstColour;
	assign ropBus.code    = ropCode;

	rop_unit u_rop (
		.px (ropBus.unit)
	);

	// Write masking decisions.
	logic [23:0] depthMask;
	logic [23:0] cmpColour;
	logic        colourSame;
	logic        patAllow;
	logic        srcAllow;
	logic        cmpAllow;

	// Only the bytes of one pixel at the engine depth take part in a compare.
	always_comb begin
		case (engineDepth)
			blit_pkg::DEPTH16: depthMask = blit_pkg::DEPTH_MASK_16;
			blit_pkg::DEPTH24: depthMask = blit_pkg::DEPTH_MASK_24;
			default:           depthMask = blit_pkg::DEPTH_MASK_8;
		endcase
	end

	always_comb begin
		patAllow = !(patMaskEn && patternMono) || patBit; // R1 R2
		srcAllow = !(srcMaskEn && sourceMono) || srcBit; // R8
		if (cmpCode[blit_pkg::CMP_DEST_BIT]) begin
			cmpColour = dstColour; // R5 R7
		end else begin
			cmpColour = ropBus.result; // R4 R6
		end
		colourSame = ((srcExpBackground ^ cmpColour) & depthMask) == 24'h00_0000;
		if (!cmpCode[blit_pkg::CMP_EN_BIT]) begin
			cmpAllow = 1'b1; // R3
		end else if (cmpCode[blit_pkg::CMP_EQ_BIT]) begin
			cmpAllow = colourSame; // R6 R7
		end else begin
			cmpAllow = !colourSame; // R4 R5
		end
	end

	// Pixel output stage; a masked pixel still passes with its write strobe low.
	logic [23:0] pixColour_q, pixColour_d;
	logic        pixWrite_q, pixWrite_d;
	logic        pixValid_q, pixValid_d;

	assign pixInReady = !pixValid_q || pixOutReady;

	always_comb begin
		pixColour_d = pixColour_q;
		pixWrite_d  = pixWrite_q;
		pixValid_d  = pixValid_q;
		if (pixInReady) begin
			pixValid_d = pixInValid;
			if (pixInValid) begin
				pixColour_d = ropBus.result; // R16
				pixWrite_d  = patAllow && srcAllow && cmpAllow; // R25
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			pixColour_q <= 24'h00_0000;
			pixWrite_q  <= 1'b0;
			pixValid_q  <= 1'b0;
		end else begin
			pixColour_q <= pixColour_d;
			pixWrite_q  <= pixWrite_d;
			pixValid_q  <= pixValid_d;
		end
	end

	assign pixOutValid  = pixValid_q;
	assign pixOutColour = pixColour_q;
	assign pixOutWrite  = pixWrite_q;
endmodule

// File: tb/blit_monitor.sv
module blit_monitor (
	input wire logic		clock,
	input wire logic		reset,
	input wire logic [22:0]	regAddr,
	input wire logic		regWrite,
	input wire logic		regRead,
	input wire logic [3:0]	regByteEn,
	input wire logic [31:0]	regWriteData,
	input wire logic [31:0]	regReadData,
	input wire logic		regReadValid,
	input wire logic		engineBusy,
	input wire blit_pkg::depth_t	engineDepth,
	input wire logic [23:0]	srcExpBackground,
	input wire logic		dataPortWrite,
	input wire logic		dataPortReady,
	input wire logic		fbSrcReady,
	input wire logic		sourceFromHost,
	input wire logic		sourceMono,
	input wire logic		patternMono,
	input wire logic		pixInValid,
	input wire logic		pixInReady,
	input wire logic		patBit,
	input wire logic		srcBit,
	input wire logic [23:0]	patColour,
	input wire logic [23:0]	srcColour,
	input wire logic [23:0]	dstColour,
	input wire logic		pixOutValid,
	input wire logic [23:0]	pixOutColour,
	input wire logic		pixOutWrite
);
	logic [31:0]	ctrlQ, ctrlD;
	logic [23:0]	ropNow, cmpNow, depthMask;
	logic			take, patOk, srcOk, wrNow;

	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// Shadow of the control register, rebuilt lane by lane from bus writes.
	always_comb begin
		ctrlD = ctrlQ;
		for (int i = 0; i < 4; i++) begin
			if (regWrite && regAddr == blit_pkg::CTRL_OFFSET && regByteEn[i]) begin
				ctrlD[8*i +: 8] = regWriteData[8*i +: 8];
			end
		end
	end

	always_ff @(posedge clock) begin
		ctrlQ <= reset ? 32'h0000_0000 : ctrlD;
	end

	// Expected pixel outcome; depth masking keeps unused colour bytes out of the compare.
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			ropNow[i] = ctrlQ[{patColour[i], srcColour[i], dstColour[i]}];
		end
		depthMask = engineDepth == blit_pkg::DEPTH24 ? blit_pkg::DEPTH_MASK_24 :
			engineDepth == blit_pkg::DEPTH16 ? blit_pkg::DEPTH_MASK_16 : blit_pkg::DEPTH_MASK_8;
		cmpNow = ctrlQ[15] ? dstColour : ropNow;
		patOk = !(ctrlQ[17] && ctrlQ[18]) || patBit;
		srcOk = !(ctrlQ[13] && ctrlQ[12]) || srcBit;
		wrNow = patOk && srcOk && (!ctrlQ[14] || (ctrlQ[16] ~^ (((srcExpBackground ^ cmpNow) & depthMask) == 24'h0)));
		take = pixInValid && pixInReady;
	end

	a_pix_result: assert property (take |=> pixOutValid && pixOutColour == $past(ropNow))
		else $error("pixel colour differs from raster op");
	a_pix_write: assert property (take |=> pixOutWrite == $past(wrNow))
		else $error("pixel write flag wrong");
	a_pat_mask: assert property (take && ctrlQ[18] && ctrlQ[17] && !patBit |=> !pixOutWrite)
		else $error("masked pattern pixel written");
	a_src_mask: assert property (take && ctrlQ[13] && ctrlQ[12] && !srcBit |=> !pixOutWrite)
		else $error("masked source pixel written");
	a_ctrl_reserved: assert property (regRead && regAddr == blit_pkg::CTRL_OFFSET |=> regReadValid && regReadData[30:26] == 5'h00 && !regReadData[11])
		else $error("reserved control bits not zero");
	a_busy_shown: assert property (regRead && regAddr == blit_pkg::CTRL_OFFSET && engineBusy |=> regReadData[31])
		else $error("busy not shown in status bit");
	a_pat_zero: assert property (regRead && regAddr == blit_pkg::PATBASE_OFFSET |=> regReadData[31:23] == 9'h000 && regReadData[2:0] == 3'h0)
		else $error("pattern base reserved bits not zero");
	a_host_ready: assert property (dataPortReady |-> sourceFromHost)
		else $error("data port ready while frame buffer selected");
	a_fb_refused: assert property (sourceFromHost |-> !fbSrcReady)
		else $error("frame buffer ready while host selected");
	a_mode_bits: assert property (##1 sourceMono == ctrlQ[12] && patternMono == ctrlQ[18] && sourceFromHost == ctrlQ[10])
		else $error("mode outputs differ from control bits");

	c_compare: cover property (take && ctrlQ[14]);
	c_host_beat: cover property (dataPortWrite && dataPortReady);
	c_masked: cover property (take && !wrNow);
endmodule

bind blit_mask_source_pattern_ctrl blit_monitor mon_u (
	.clock, .reset, .regAddr, .regWrite, .regRead, .regByteEn, .regWriteData, .regReadData, .regReadValid,
	.engineBusy, .engineDepth, .srcExpBackground, .dataPortWrite, .dataPortReady, .fbSrcReady,
	.sourceFromHost, .sourceMono, .patternMono, .pixInValid, .pixInReady, .patBit, .srcBit,
	.patColour, .srcColour, .dstColour, .pixOutValid, .pixOutColour, .pixOutWrite
);

// File: tb/host_port.sv
module host_port (
	input wire logic	clock,
	input wire logic	dataPortReady,
	output logic		dataPortWrite,
	output logic [31:0]	dataPortData
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus after time zero.
	initial begin
		dataPortWrite = 1'b0;
		dataPortData = 32'h0000_0000;
	end

	// One data-port beat, held until the block takes it; a bounded wait keeps a dead port from hanging us.
	// The caller learns through taken whether the beat went in, so a refused beat can be counted.
	task automatic push(input logic [31:0] w, output logic taken);
		int n;
		@(posedge clock);
		dataPortWrite <= 1'b1;
		dataPortData <= w;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (!dataPortReady && n < 16);
		taken = dataPortReady;
		dataPortWrite <= 1'b0;
		dataPortData <= ~w; // A released bus must not keep showing the old word.
	endtask
endmodule

// File: tb/blit_mask_source_pattern_ctrl_tb.sv
module blit_mask_source_pattern_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic			clock, reset, regWrite, regRead, engineBusy, fbSrcValid, pixInValid, patBit, srcBit, patFetchStart;
	logic			regReadValid, dataPortWrite, dataPortReady, fbSrcReady, srcOutValid, pixOutValid, pixOutWrite;
	logic			sourceFromHost, sourceMono, patternMono, startRight, startBottom, patFetchValid, pixInReady;
	logic			srcOutReady, pushOk;
	logic [22:0]	regAddr, patFetchAddr;
	logic [3:0]		regByteEn;
	logic [31:0]	regWriteData, regReadData, dataPortData, fbSrcData, srcOutData;
	logic [23:0]	srcExpBackground, patColour, srcColour, dstColour, pixOutColour;
	logic [7:0]		codes [5] = '{8'hcc, 8'hf0, 8'haa, 8'h66, 8'h96};
	blit_pkg::depth_t	engineDepth;
	blit_pkg::corner_t	startCorner;
	int				errorCnt = 0;
	int				numChecks = 0;

	// Pixel and fetch outputs are never stalled, so their ready inputs are tied; the source stream is stalled once.
	blit_mask_source_pattern_ctrl dut_u (
		.clock, .reset, .regAddr, .regWrite, .regRead, .regByteEn, .regWriteData, .regReadData, .regReadValid,
		.engineBusy, .engineDepth, .srcExpBackground, .dataPortWrite, .dataPortData, .dataPortReady,
		.fbSrcValid, .fbSrcData, .fbSrcReady, .srcOutValid, .srcOutData, .srcOutReady,
		.pixInValid, .pixInReady, .patBit, .srcBit, .patColour, .srcColour, .dstColour, .pixOutValid,
		.pixOutColour, .pixOutWrite, .pixOutReady(1'b1), .sourceFromHost, .sourceMono, .patternMono,
		.startCorner, .startRight, .startBottom, .patFetchStart, .patFetchReady(1'b1), .patFetchValid, .patFetchAddr
	);
	host_port host_u (.clock, .dataPortReady, .dataPortWrite, .dataPortData);

	// Free-running clock.
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic giveVerdict();
		$display("checks=%0d errors=%0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [22:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWriteData <= d;
		regByteEn <= 4'hf;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic rd(input logic [22:0] a, input logic [31:0] exp);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		chk(regReadValid, 1'b1);
		chk(regReadData, exp);
	endtask

	task automatic pix(input logic [23:0] s, d, input logic pb, sb, wrExp, input logic [23:0] colExp);
		@(posedge clock);
		{patColour, srcColour, dstColour, patBit, srcBit} <= {24'h0f0f0f, s, d, pb, sb};
		pixInValid <= 1'b1;
		@(posedge clock);
		pixInValid <= 1'b0;
		#1;
		chk(pixOutValid, 1'b1);
		chk(pixOutWrite, wrExp);
		chk(pixOutColour, colExp);
	endtask

	// Walks one pattern fetch and checks every address against row size and stride.
	task automatic fetch(input int bytes, input int stride);
		@(posedge clock);
		patFetchStart <= 1'b1;
		@(posedge clock);
		patFetchStart <= 1'b0;
		for (int i = 0; i < 8 * bytes; i++) begin
			#1;
			chk(patFetchValid, 1'b1);
			chk(patFetchAddr, 32'h100 + stride * (i / bytes) + i % bytes);
			@(posedge clock);
		end
		#1;
		chk(patFetchValid, 1'b0);
	endtask

	function automatic logic [23:0] ropf(input logic [7:0] c, input logic [23:0] p, s, d);
		for (int i = 0; i < 24; i++) begin
			ropf[i] = c[{p[i], s[i], d[i]}];
		end
	endfunction

	// Watchdog against a hung run.
	initial begin
		repeat (20000) @(posedge clock);
		errorCnt++;
		giveVerdict();
	end

	initial begin
		{reset, regWrite, regRead, engineBusy, fbSrcValid, pixInValid, patBit, srcBit, patFetchStart} = 9'h001 << 8;
		{regAddr, regByteEn, regWriteData, fbSrcData, patColour, srcColour, dstColour} = '0;
		srcOutReady = 1'b1;
		srcExpBackground = 24'h123456;
		engineDepth = blit_pkg::DEPTH24;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		rd(blit_pkg::CTRL_OFFSET, 32'h0);
		rd(blit_pkg::PATBASE_OFFSET, 32'h0);
		wr(blit_pkg::CTRL_OFFSET, 32'hffff_ffff);
		rd(blit_pkg::CTRL_OFFSET, 32'h03ff_f7ff);
		engineBusy <= 1'b1;
		rd(blit_pkg::CTRL_OFFSET, 32'h83ff_f7ff);
		engineBusy <= 1'b0;
		wr(blit_pkg::PATBASE_OFFSET, 32'hffff_ffff);
		rd(blit_pkg::PATBASE_OFFSET, 32'h007f_fff8);
		rd(23'h40_0030, 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(blit_pkg::CTRL_OFFSET, 32'(c) << 8);
			#1;
			chk(startCorner, c);
			chk({startBottom, startRight}, c);
		end
		wr(blit_pkg::CTRL_OFFSET, 32'h0004_1400);
		#1;
		chk({patternMono, sourceMono, sourceFromHost, fbSrcReady}, 4'he);
		for (int w = 0; w < 3; w++) begin
			host_u.push(32'hc0de_0000 + w, pushOk);
			#1;
			chk(pushOk, 1'b1);
			chk(srcOutValid, 1'b1);
			chk(srcOutData, 32'hc0de_0000 + w);
		end
		// A stalled stream keeps its last word standing and refuses the next host beat.
		srcOutReady <= 1'b0;
		host_u.push(32'hbeef_0001, pushOk);
		srcOutReady <= 1'b1;
		#1;
		chk(pushOk, 1'b0);
		chk(srcOutValid, 1'b1);
		chk(srcOutData, 32'hc0de_0002);
		wr(blit_pkg::CTRL_OFFSET, 32'h0);
		fbSrcValid <= 1'b1;
		fbSrcData <= 32'h5a5a_1234;
		@(posedge clock);
		fbSrcValid <= 1'b0;
		#1;
		chk(dataPortReady, 1'b0);
		chk(srcOutValid, 1'b1);
		chk(srcOutData, 32'h5a5a_1234);
		foreach (codes[i]) begin
			wr(blit_pkg::CTRL_OFFSET, {24'h0, codes[i]});
			pix(24'h3c3c3c, 24'h55aa55, 0, 0, 1, ropf(codes[i], 24'h0f0f0f, 24'h3c3c3c, 24'h55aa55));
		end
		wr(blit_pkg::CTRL_OFFSET, 32'h0006_00cc);
		pix(24'h1, 24'h2, 0, 0, 0, 24'h1);
		pix(24'h1, 24'h2, 1, 0, 1, 24'h1);
		wr(blit_pkg::CTRL_OFFSET, 32'h0002_00cc);
		pix(24'h1, 24'h2, 0, 0, 1, 24'h1);
		wr(blit_pkg::CTRL_OFFSET, 32'h0000_30cc);
		pix(24'h1, 24'h2, 1, 0, 0, 24'h1);
		pix(24'h1, 24'h2, 0, 1, 1, 24'h1);
		wr(blit_pkg::CTRL_OFFSET, 32'h0006_30cc);
		pix(24'h1, 24'h2, 0, 1, 0, 24'h1);
		for (int k = 0; k < 4; k++) begin
			wr(blit_pkg::CTRL_OFFSET, 32'h0000_00cc | (32'(2 * k + 1) << 14));
			pix(k[0] ? 24'h654321 : 24'h123456, k[0] ? 24'h123456 : 24'h654321, 0, 0, k[1],
				k[0] ? 24'h654321 : 24'h123456);
			pix(24'h111111, 24'h222222, 0, 0, !k[1], 24'h111111);
		end
		wr(blit_pkg::CTRL_OFFSET, 32'h0001_80cc);
		pix(24'h123456, 24'h0, 0, 0, 1, 24'h123456);
		wr(blit_pkg::PATBASE_OFFSET, 32'h100);
		fetch(24, 32);
		engineDepth <= blit_pkg::DEPTH8;
		fetch(8, 8);
		engineDepth <= blit_pkg::DEPTH16;
		fetch(16, 16);
		// At 16 bits per pixel the top colour byte stays out of the compare.
		wr(blit_pkg::CTRL_OFFSET, 32'h0001_40cc);
		pix(24'hff3456, 24'h0, 0, 0, 1, 24'hff3456);
		wr(blit_pkg::CTRL_OFFSET, 32'h0004_0000);
		fetch(1, 1);
		giveVerdict();
	end
endmodule
